// File: common/ubx_cfg.svh
// Register map, field positions and reset values of the serial port block
// What this block does
// - With transmit enabled and holding register empty, raise transmit interrupt at once.
// - Software picks ninth bit per byte; device sends it as address/data marker.
// - Byte written to transmit data moves automatically into shifter and goes out.
// - With clear-to-send gate on, CTS input holds transmission; off, CTS ignored.
// - Receiver samples the line only while receive enable is set.
// - Optional even/odd parity check on received bytes (transmit sends ninth bit as set), usable only while multiprocessor mode is off.
// - Data-available flag reads 1 while receive register holds a byte, else 0.
// - In multiprocessor mode, mode field decides handling around received bytes.
// - Baud readback bit 0: baud high/low reads return reload value.
// - Receiver off, readback bit 1: generator interrupts at zero, reads show count.
// - Receiver on, readback bit 1: baud reads return the live count.
// - Filter bit 0: data and errors interrupt; 1: only errors interrupt.
// - Infrared bit 1 routes all serial data through infrared encoder/decoder.
`ifndef UBX_CFG_SVH
`define UBX_CFG_SVH
// Register indices (byte address is four times the index)
`define UBX_I_DATA  3'h0
`define UBX_I_STAT  3'h1
`define UBX_I_CTL0  3'h2
`define UBX_I_CTL1  3'h3
`define UBX_I_BRGH  3'h4
`define UBX_I_BRGL  3'h5
`define UBX_I_IST   3'h6
`define UBX_I_IMSK  3'h7
// Control 0 fields
`define UBX_C0_TEN  0
`define UBX_C0_REN  1
`define UBX_C0_CTSG 2
`define UBX_C0_PEN  3
`define UBX_C0_PODD 4
// Control 1 fields
`define UBX_C1_IR   0
`define UBX_C1_EONL 1
`define UBX_C1_BRRD 2
`define UBX_C1_NINB 4
`define UBX_C1_MPEN 5
`define UBX_C1_MODL 6
`define UBX_C1_MODH 7
// Interrupt status bits
`define UBX_IRQ_TX  0
`define UBX_IRQ_RX  1
`define UBX_IRQ_ERR 2
`define UBX_IRQ_BRG 3
// Reset values
`define UBX_RST_CTL 8'h00
`define UBX_RST_BRG 16'h0000
// Bit timing
`define UBX_OVS_LAST 4'hf
`define UBX_OVS_MID  4'h7
`define UBX_IR_LAST  4'h2
`define UBX_IR_HOLD  5'h10
`define UBX_BITS_9   4'h9
`define UBX_BITS_10  4'ha
`endif

// File: common/ubx_pkg.sv
// Types shared by the serial port block
package ubx_pkg;
  typedef enum logic [0:0] {UBX_TX_IDLE, UBX_TX_RUN} ubx_txs_t;
  typedef enum logic [1:0] {UBX_RX_IDLE, UBX_RX_START, UBX_RX_BITS} ubx_rxs_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ubx_brg_st_t;

  typedef struct packed {
    ubx_txs_t    txs;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_cnt;
    logic [10:0] tx_sh;
    logic        txd;
    ubx_rxs_t    rxs;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_cnt;
    logic [9:0]  rx_sh;
    logic [4:0]  ir_hold;
    logic        rx_valid;
    logic [8:0]  rx_data;
    logic        perr;
    logic        ferr;
  } ubx_sh_st_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        irq;
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [15:0] brg;
    logic [8:0]  tx_hold;
    logic        tx_full;
    logic        tx_load;
    logic [8:0]  rx_data;
    logic        rx_perr;
    logic        rx_ferr;
    logic        rx_avail;
    logic [8:0]  pend_data;
    logic        pend_perr;
    logic        pend_ferr;
    logic        pend_full;
    logic [3:0]  ist;
    logic [3:0]  imsk;
  } ubx_top_st_t;
endpackage

// File: common/ubx_ser_if.sv
// Link between register side and serial shift engine
`timescale 1ns/1ns
`default_nettype none
interface ubx_ser_if;
  logic       tick;
  logic       ir_en;
  logic       ren;
  logic       nine_en;
  logic       par_en;
  logic       par_odd;
  logic       tx_load;
  logic [8:0] tx_frame;
  logic       tx_busy;
  logic       rx_valid;
  logic [8:0] rx_data;
  logic       rx_perr;
  logic       rx_ferr;

  modport ctl (output tick, ir_en, ren, nine_en, par_en, par_odd, tx_load, tx_frame,
               input tx_busy, rx_valid, rx_data, rx_perr, rx_ferr);
  modport eng (input tick, ir_en, ren, nine_en, par_en, par_odd, tx_load, tx_frame,
               output tx_busy, rx_valid, rx_data, rx_perr, rx_ferr);
endinterface // ubx_ser_if
`default_nettype wire

// File: verilog/ubx_baud.sv
// Baud generator: reloading down counter giving an oversampling tick
`timescale 1ns/1ns
`default_nettype none
module ubx_baud (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Reload value and outputs
  input  wire logic [15:0] reload_i,
  output logic             tick_o,
  output logic [15:0]      count_o
);
  import ubx_pkg::*;

  ubx_brg_st_t s_ff;
  ubx_brg_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == 16'h0000) begin
      nxt_s.cnt  = reload_i;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick_o  = s_ff.tick;
  assign count_o = s_ff.cnt;
endmodule // ubx_baud
`default_nettype wire

// File: verilog/ubx_shift.sv
// Serial shift engine: transmit and receive framing, parity, infrared codec
`timescale 1ns/1ns
`default_nettype none
`include "ubx_cfg.svh"
module ubx_shift (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Register side
  ubx_ser_if.eng    sif,
  // Serial pins
  input  wire logic rxd_i,
  output logic      txd_o
);
  import ubx_pkg::*;

  ubx_sh_st_t s_ff;
  ubx_sh_st_t nxt_s;
  logic       line;
  logic [8:0] dat9;

  // Infrared decoder stretches each short pulse into a low bit
  assign line = sif.ir_en ? (s_ff.ir_hold == 5'h00) : rxd_i;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rx_valid = 1'b0;
    dat9 = '0;
    // ************************************************************
    // Transmit
    // ************************************************************
    if (s_ff.txs == UBX_TX_IDLE) begin
      if (sif.tx_load) begin
        nxt_s.txs    = UBX_TX_RUN;
        nxt_s.tx_sub = '0;
        if (sif.nine_en || sif.par_en) begin
          nxt_s.tx_sh  = {1'b1, sif.tx_frame, 1'b0};
          nxt_s.tx_cnt = `UBX_BITS_10 + 4'h1;
        end else begin
          nxt_s.tx_sh  = {2'b11, sif.tx_frame[7:0], 1'b0};
          nxt_s.tx_cnt = `UBX_BITS_10;
        end
      end
    end else if (sif.tick) begin
      nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
      if (s_ff.tx_sub == `UBX_OVS_LAST) begin
        nxt_s.tx_sh  = {1'b1, s_ff.tx_sh[10:1]};
        nxt_s.tx_cnt = s_ff.tx_cnt - 4'h1;
        if (s_ff.tx_cnt == 4'h1) begin
          nxt_s.txs = UBX_TX_IDLE;
        end
      end
    end
    // infrared encoder sends a short pulse for each zero
    if (sif.ir_en) begin
      nxt_s.txd = (s_ff.txs == UBX_TX_RUN) && !s_ff.tx_sh[0] &&
                  (s_ff.tx_sub <= `UBX_IR_LAST);
    end else begin
      nxt_s.txd = (s_ff.txs == UBX_TX_RUN) ? s_ff.tx_sh[0] : 1'b1;
    end
    // ************************************************************
    // Receive
    // ************************************************************
    if (sif.ir_en && rxd_i) begin
      nxt_s.ir_hold = `UBX_IR_HOLD;
    end else if (sif.tick && s_ff.ir_hold != 5'h00) begin
      nxt_s.ir_hold = s_ff.ir_hold - 5'h01;
    end
    case (s_ff.rxs)
      UBX_RX_IDLE: begin
        if (sif.ren && !line) begin
          nxt_s.rxs    = UBX_RX_START;
          nxt_s.rx_sub = '0;
        end
      end
      UBX_RX_START: begin
        if (sif.tick) begin
          nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
          if (s_ff.rx_sub == `UBX_OVS_MID) begin
            nxt_s.rxs    = line ? UBX_RX_IDLE : UBX_RX_BITS;
            nxt_s.rx_sub = '0;
            nxt_s.rx_cnt = '0;
          end
        end
      end
      UBX_RX_BITS: begin
        if (sif.tick) begin
          nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
          if (s_ff.rx_sub == `UBX_OVS_LAST) begin
            nxt_s.rx_sh  = {line, s_ff.rx_sh[9:1]};
            nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
            if (nxt_s.rx_cnt == ((sif.nine_en || sif.par_en) ? `UBX_BITS_10 : `UBX_BITS_9)) begin
              nxt_s.rxs = UBX_RX_IDLE;
              if (sif.nine_en || sif.par_en) begin
                dat9 = nxt_s.rx_sh[8:0];
              end else begin
                dat9 = {1'b0, nxt_s.rx_sh[8:1]};
              end
              nxt_s.rx_valid = 1'b1;
              nxt_s.rx_data  = dat9;
              // parity bit checked in the ninth slot
              nxt_s.perr = sif.par_en && ((^dat9) != sif.par_odd);
              nxt_s.ferr = !nxt_s.rx_sh[9];
            end
          end
        end
      end
      default: nxt_s.rxs = UBX_RX_IDLE;
    endcase
    if (!sif.ren) begin
      nxt_s.rxs = UBX_RX_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff     <= '0;
      s_ff.txd <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign txd_o        = s_ff.txd;
  assign sif.tx_busy  = (s_ff.txs == UBX_TX_RUN);
  assign sif.rx_valid = s_ff.rx_valid;
  assign sif.rx_data  = s_ff.rx_data;
  assign sif.rx_perr  = s_ff.perr;
  assign sif.rx_ferr  = s_ff.ferr;
endmodule // ubx_shift
`default_nettype wire

// File: verilog/ubx_top.sv
// Serial port block with Wishbone registers, interrupts and infrared option
`timescale 1ns/1ns
`default_nettype none
`include "ubx_cfg.svh"
module ubx_top #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // Interrupt
  output logic               irq_o,
  // Serial pins
  input  wire logic          rxd_i,
  input  wire logic          cts_n_i,
  output logic               txd_o
);
  import ubx_pkg::*;

  ubx_top_st_t s_ff;
  ubx_top_st_t nxt_s;

  ubx_ser_if   sif ();
  logic        brg_tick;
  logic [15:0] brg_count;

  // ************************************************************
  // Submodules
  // ************************************************************
  ubx_baud u_baud (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .reload_i (s_ff.brg),
    .tick_o   (brg_tick),
    .count_o  (brg_count)
  );

  ubx_shift u_shift (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif),
    .rxd_i (rxd_i),
    .txd_o (txd_o)
  );

  // ************************************************************
  // Decoded controls
  // ************************************************************
  logic ten;
  logic ren;
  logic mp_en;
  logic [1:0] mp_mode;
  logic cts_ok;
  logic [15:0] brg_rb;

  assign ten     = s_ff.ctl0[`UBX_C0_TEN];
  assign ren     = s_ff.ctl0[`UBX_C0_REN];
  assign mp_en   = s_ff.ctl1[`UBX_C1_MPEN];
  assign mp_mode = {s_ff.ctl1[`UBX_C1_MODH], s_ff.ctl1[`UBX_C1_MODL]};
  assign cts_ok  = !s_ff.ctl0[`UBX_C0_CTSG] || !cts_n_i;
  // readback picks reload or live count
  // live count also with receiver on
  assign brg_rb  = s_ff.ctl1[`UBX_C1_BRRD] ? brg_count : s_ff.brg;

  assign sif.tick     = brg_tick;
  assign sif.ir_en    = s_ff.ctl1[`UBX_C1_IR];
  assign sif.ren      = ren;
  assign sif.nine_en  = mp_en;
  // parity forced off in multiprocessor mode
  assign sif.par_en   = s_ff.ctl0[`UBX_C0_PEN] && !mp_en;
  assign sif.par_odd  = s_ff.ctl0[`UBX_C0_PODD];
  assign sif.tx_load  = s_ff.tx_load;
  assign sif.tx_frame = s_ff.tx_hold;

  // ************************************************************
  // Bus access
  // ************************************************************
  logic       hit;
  logic       mapped;
  logic [2:0] idx;
  logic       wr;
  logic       rd;

  assign hit    = wb_cyc_i && wb_stb_i;
  assign idx    = wb_adr_i[4:2];
  assign mapped = (wb_adr_i[AW-1:5] == '0) && (wb_adr_i[1:0] == 2'h0);
  assign wr     = hit && s_ff.ack && wb_we_i && wb_sel_i[0] && mapped;
  assign rd     = hit && s_ff.ack && !wb_we_i && mapped;

  logic [7:0] stat0;
  logic [7:0] rdv;

  always_comb begin
    stat0 = '0;
    stat0[0] = s_ff.rx_avail;
    stat0[1] = !s_ff.tx_full;
    stat0[2] = !s_ff.tx_full && !sif.tx_busy && !s_ff.tx_load;
    stat0[3] = s_ff.rx_perr;
    stat0[4] = s_ff.rx_ferr;
    stat0[5] = s_ff.pend_full;
    stat0[6] = s_ff.rx_data[8];
    stat0[7] = !cts_n_i;
    case (idx)
      `UBX_I_DATA: rdv = s_ff.rx_data[7:0];
      `UBX_I_STAT: rdv = stat0;
      `UBX_I_CTL0: rdv = s_ff.ctl0;
      `UBX_I_CTL1: rdv = s_ff.ctl1;
      `UBX_I_BRGH: rdv = brg_rb[15:8];
      `UBX_I_BRGL: rdv = brg_rb[7:0];
      `UBX_I_IST:  rdv = {4'h0, s_ff.ist};
      `UBX_I_IMSK: rdv = {4'h0, s_ff.imsk};
      default:     rdv = '0;
    endcase
    if (!mapped) begin
      rdv = '0;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  logic [3:0] ev;
  logic [3:0] clr;
  logic       accept;
  logic       ovr;

  always_comb begin
    nxt_s = s_ff;
    ev    = '0;
    clr   = '0;
    ovr   = 1'b0;
    // Classic single-cycle handshake, one wait state
    nxt_s.ack = hit && !s_ff.ack;
    if (hit && !s_ff.ack) begin
      nxt_s.dat = {24'h000000, rdv};
    end

    // Transmit: holding register feeds the shifter
    nxt_s.tx_load = 1'b0;
    if (s_ff.tx_full && !s_ff.tx_load && !sif.tx_busy && ten && cts_ok) begin
      nxt_s.tx_load = 1'b1;
      nxt_s.tx_full = 1'b0;
    end

    // Register writes
    if (wr) begin
      case (idx)
        `UBX_I_DATA: begin
          if (!nxt_s.tx_full) begin
            // ninth bit travels with the byte
            nxt_s.tx_hold = {s_ff.ctl1[`UBX_C1_NINB], wb_dat_i[7:0]};
            nxt_s.tx_full = 1'b1;
          end
        end
        `UBX_I_CTL0: nxt_s.ctl0 = wb_dat_i[7:0];
        `UBX_I_CTL1: nxt_s.ctl1 = wb_dat_i[7:0];
        `UBX_I_BRGH: nxt_s.brg[15:8] = wb_dat_i[7:0];
        `UBX_I_BRGL: nxt_s.brg[7:0] = wb_dat_i[7:0];
        `UBX_I_IST:  clr = wb_dat_i[3:0];
        `UBX_I_IMSK: nxt_s.imsk = wb_dat_i[3:0];
        default: nxt_s.imsk = nxt_s.imsk;
      endcase
    end

    // read pops the receive register, a waiting byte refills it
    if (rd && idx == `UBX_I_DATA) begin
      if (s_ff.pend_full) begin
        nxt_s.rx_data   = s_ff.pend_data;
        nxt_s.rx_perr   = s_ff.pend_perr;
        nxt_s.rx_ferr   = s_ff.pend_ferr;
        nxt_s.pend_full = 1'b0;
      end else begin
        nxt_s.rx_avail = 1'b0;
      end
    end

    // mode bit 0 drops data bytes; in mode 3 only until an address byte arrives
    accept = sif.rx_valid &&
             !(mp_en && mp_mode[0] && !sif.rx_data[8]);
    if (accept) begin
      // mode 3 wakes on address byte
      if (mp_en && mp_mode == 2'h3 && sif.rx_data[8]) begin
        nxt_s.ctl1[`UBX_C1_MODL] = 1'b0;
      end
      if (!nxt_s.rx_avail) begin
        nxt_s.rx_data  = sif.rx_data;
        nxt_s.rx_perr  = sif.rx_perr;
        nxt_s.rx_ferr  = sif.rx_ferr;
        // set wins over a pop in the same cycle
        nxt_s.rx_avail = 1'b1;
      end else if (!nxt_s.pend_full) begin
        nxt_s.pend_data = sif.rx_data;
        nxt_s.pend_perr = sif.rx_perr;
        nxt_s.pend_ferr = sif.rx_ferr;
        nxt_s.pend_full = 1'b1;
      end else begin
        ovr = 1'b1;
      end
    end

    // Interrupt events
    // empty holding register requests at once
    ev[`UBX_IRQ_TX]  = ten && !nxt_s.tx_full;
    // data requests unless filtered, errors always
    ev[`UBX_IRQ_RX]  = accept && !s_ff.ctl1[`UBX_C1_EONL];
    ev[`UBX_IRQ_ERR] = (accept && (sif.rx_perr || sif.rx_ferr)) || ovr;
    // generator as timer with receiver off
    ev[`UBX_IRQ_BRG] = brg_tick && !ren && s_ff.ctl1[`UBX_C1_BRRD];
    nxt_s.ist = (s_ff.ist & ~clr) | ev;
    nxt_s.irq = |(nxt_s.ist & nxt_s.imsk);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff      <= '0;
      s_ff.ctl0 <= `UBX_RST_CTL;
      s_ff.ctl1 <= `UBX_RST_CTL;
      s_ff.brg  <= `UBX_RST_BRG;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.dat;
  assign irq_o    = s_ff.irq;
endmodule // ubx_top
`default_nettype wire

// File: tb/ubx_top_properties.sv
// Concurrent checks on the ports of the serial port block
`timescale 1ns/1ns
`default_nettype none
module ubx_top_properties #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [31:0]   wb_dat_o,
  input  wire logic          wb_ack_o,
  // Interrupt and serial pins
  input  wire logic          irq_o,
  input  wire logic          rxd_i,
  input  wire logic          cts_n_i,
  input  wire logic          txd_o
);
  // ****************************************
  // Shadow copies of written registers
  // ****************************************
  logic [7:0] c0_ff, c1_ff, msk_ff, brl_ff;
  logic       wrd_ff, ren_ff, wr_ev;
  assign wr_ev = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c0_ff  <= 8'h00;
      c1_ff  <= 8'h00;
      msk_ff <= 8'h00;
      brl_ff <= 8'h00;
      wrd_ff <= 1'b0;
      ren_ff <= 1'b0;
    end else begin
      if (wr_ev && wb_adr_i == AW'(8'h08)) c0_ff <= wb_dat_i[7:0];
      if (wr_ev && wb_adr_i == AW'(8'h0c)) c1_ff <= wb_dat_i[7:0];
      if (wr_ev && wb_adr_i == AW'(8'h1c)) msk_ff <= wb_dat_i[7:0];
      if (wr_ev && wb_adr_i == AW'(8'h14)) brl_ff <= wb_dat_i[7:0];
      if (wr_ev && wb_adr_i == AW'(8'h00)) wrd_ff <= 1'b1;
      if (c0_ff[1]) ren_ff <= 1'b1;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_RST_IDLE: assert property (disable iff (1'b0) rst_i |=> txd_o && !irq_o && !wb_ack_o)
    else $error("outputs not idle after reset");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_BAUD_RELOAD: assert property (wb_ack_o && !wb_we_i && wb_adr_i == AW'(8'h14) && !c1_ff[2]
    |-> wb_dat_o == {24'h000000, brl_ff})
    else $error("baud read not reload value");
  AST_TXD_HOLD: assert property ($changed(txd_o) |=> $stable(txd_o) [*2])
    else $error("serial output glitch");
  AST_MASK_IRQ: assert property (msk_ff[3:0] == 4'h0 && $past(msk_ff[3:0]) == 4'h0 |-> !irq_o)
    else $error("interrupt with all sources masked");
  AST_TX_IRQ: assert property ($rose(c0_ff[0]) && msk_ff[0] && !wrd_ff |-> ##[1:3] irq_o)
    else $error("no transmit interrupt on empty register");
  AST_RX_GATE: assert property (wb_ack_o && !wb_we_i && wb_adr_i == AW'(8'h04) && !ren_ff
    |-> wb_dat_o[0] == 1'b0)
    else $error("byte received while receiver off");
  cover property (wb_ack_o && wb_we_i);
  cover property ($fell(txd_o));
  cover property ($rose(irq_o));
endmodule // ubx_top_properties
bind ubx_top ubx_top_properties #(.AW(AW)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .rxd_i(rxd_i), .cts_n_i(cts_n_i), .txd_o(txd_o));
`default_nettype wire

// File: tb/ubx_remote_model.sv
// Remote serial transceiver facing the block across the line
`timescale 1ns/1ns
`default_nettype none
module ubx_remote_model #(
  parameter int BIT_CLK = 32
) (
  // Clock and line
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [8:0]  got_q;
  logic [10:0] f;
  int          got_n;
  initial begin
    line_o = 1'b1;
    got_q  = 9'h000;
    got_n  = 0;
  end
  // sample eight data bits then ninth
  always begin
    @(negedge line_i);
    repeat (BIT_CLK / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLK) @(posedge clk_i);
      got_q[i] = line_i;
    end
    got_n++;
  end
  // Start, data LSB first, optional ninth bit, stop; line idles high
  task automatic send(input logic [8:0] v, input int nb);
    f = (nb == 8) ? {3'b111, v[7:0]} : {2'b11, v};
    line_o <= 1'b0;
    repeat (BIT_CLK) @(posedge clk_i);
    for (int i = 0; i <= nb; i++) begin
      line_o <= f[i];
      repeat (BIT_CLK) @(posedge clk_i);
    end
  endtask
endmodule // ubx_remote_model
`default_nettype wire

// File: tb/uart_irq_rx_tx_control_tb.sv
// Self-checking register-level bench of the serial port block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module uart_irq_rx_tx_control_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq, txd, rxd, cts_n;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, v, w;
  int          err_total, cmp_count;
  ubx_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .rxd_i(rxd), .cts_n_i(cts_n), .txd_o(txd));
  ubx_remote_model #(.BIT_CLK(32)) rem_u (.clk_i(clk_i), .line_i(txd), .line_o(rxd));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ****************************************
  // Bus cycles and helpers
  // ****************************************
  task automatic wb(input logic w_e, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w_e;
    adr  <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, w);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask
  task automatic wait_rx(input int k);
    int n;
    n = 0;
    while (rem_u.got_n < k && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) err_total++;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    finish_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {cyc, stb, we, adr, wdat, cts_n} = '0;
    rst_i = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h04, v);
    `CHK("status", 32'h86, v)
    rd(8'h21, v);
    `CHK("unmapped", 32'h0, v)
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h1c, 8'h01);
    wr(8'h08, 8'h01);
    repeat (3) @(posedge clk_i);
    `CHK("tx_irq", 1'b1, irq)
    wr(8'h0c, 8'h30);
    wr(8'h00, 8'ha5);
    wr(8'h18, 8'h01);
    wait_rx(1);
    `CHK("addr_byte", 9'h1a5, rem_u.got_q)
    wr(8'h0c, 8'h20);
    wr(8'h00, 8'h3c);
    wait_rx(2);
    `CHK("data_byte", 9'h03c, rem_u.got_q)
    $display("test transmit done");
    wr(8'h08, 8'h05);
    cts_n <= 1'b1;
    wr(8'h00, 8'h55);
    repeat (600) @(posedge clk_i);
    `CHK("cts_hold", 2, rem_u.got_n)
    cts_n <= 1'b0;
    wait_rx(3);
    `CHK("cts_go", 9'h055, rem_u.got_q)
    wr(8'h08, 8'h01);
    cts_n <= 1'b1;
    wr(8'h00, 8'h66);
    wait_rx(4);
    `CHK("cts_off", 9'h066, rem_u.got_q)
    cts_n <= 1'b0;
    $display("test clear to send done");
    wr(8'h0c, 8'h00);
    rem_u.send(9'h05a, 8);
    rd(8'h04, v);
    `CHK("rx_off", 1'b0, v[0])
    wr(8'h18, 8'h0e);
    wr(8'h1c, 8'h02);
    wr(8'h08, 8'h03);
    rem_u.send(9'h05a, 8);
    rem_u.send(9'h0c3, 8);
    rd(8'h04, v);
    `CHK("avail", 2'b11, {v[5], v[0]})
    `CHK("rx_irq", 1'b1, irq)
    rd(8'h00, v);
    `CHK("byte1", 32'h5a, v)
    rd(8'h04, v);
    `CHK("still", 1'b1, v[0])
    rd(8'h00, v);
    `CHK("byte2", 32'hc3, v)
    rd(8'h04, v);
    `CHK("empty", 1'b0, v[0])
    wr(8'h0c, 8'h02);
    wr(8'h18, 8'h0e);
    rem_u.send(9'h033, 8);
    rd(8'h18, v);
    `CHK("filt_data", 2'b00, v[2:1])
    rd(8'h00, v);
    wr(8'h08, 8'h0b);
    rem_u.send(9'h001, 9);
    rd(8'h18, v);
    `CHK("filt_err", 2'b10, v[2:1])
    rd(8'h04, v);
    `CHK("even_bad", 1'b1, v[3])
    rd(8'h00, v);
    rem_u.send(9'h101, 9);
    rd(8'h04, v);
    `CHK("even_ok", 1'b0, v[3])
    rd(8'h00, v);
    wr(8'h08, 8'h1b);
    rem_u.send(9'h001, 9);
    rd(8'h04, v);
    `CHK("odd_ok", 1'b0, v[3])
    rd(8'h00, v);
    $display("test receive done");
    wr(8'h08, 8'h03);
    wr(8'h0c, 8'h60);
    rem_u.send(9'h012, 9);
    rd(8'h04, v);
    `CHK("mp_drop", 1'b0, v[0])
    rem_u.send(9'h1a7, 9);
    rd(8'h04, v);
    `CHK("mp_addr", 2'b11, {v[6], v[0]})
    rd(8'h00, v);
    `CHK("mp_byte", 32'ha7, v)
    wr(8'h0c, 8'he0);
    rem_u.send(9'h1b2, 9);
    rd(8'h0c, v);
    `CHK("mp_wake", 32'ha0, v)
    rd(8'h00, v);
    `CHK("wake_byte", 32'hb2, v)
    $display("test multiprocessor done");
    wr(8'h08, 8'h01);
    wr(8'h14, 8'h80);
    wr(8'h0c, 8'h04);
    wr(8'h1c, 8'h08);
    wr(8'h18, 8'h08);
    repeat (300) @(posedge clk_i);
    `CHK("brg_irq", 1'b1, irq)
    rd(8'h14, v);
    rd(8'h14, w);
    `CHK("live_off", 1'b1, v !== w)
    wr(8'h08, 8'h03);
    rd(8'h14, v);
    rd(8'h14, w);
    `CHK("live_on", 1'b1, v !== w)
    wr(8'h0c, 8'h00);
    rd(8'h14, v);
    `CHK("reload", 32'h80, v)
    wr(8'h0c, 8'h01);
    repeat (4) @(posedge clk_i);
    `CHK("ir_idle", 1'b0, txd)
    $display("test baud and infrared done");
    finish_test();
  end
endmodule // uart_irq_rx_tx_control_tb
`default_nettype wire
